/* sas_consts.svh */
// Constants for the sample accumulate and shift unit.
// Assumes inclusion by the unit and the bench; definitions only.
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH

// -------------------------------------------------------------
// Register addresses in the special-function space
// -------------------------------------------------------------
`define SAS_ADDR_CTRL 8'hE1
`define SAS_ADDR_SUM0 8'hE2
`define SAS_ADDR_SUM1 8'hE3
`define SAS_ADDR_SUM2 8'hE4
`define SAS_ADDR_SUM3 8'hE5

// -------------------------------------------------------------
// Control field layout and reset values
// -------------------------------------------------------------
`define SAS_MODE_HI 7
`define SAS_MODE_LO 6
`define SAS_CNT_HI 5
`define SAS_CNT_LO 3
`define SAS_SHF_HI 2
`define SAS_SHF_LO 0
`define SAS_CTRL_RESET 8'h00
`define SAS_ACC_RESET 32'h0000_0000
`define SAS_UNMAPPED_READ 8'h00

// -------------------------------------------------------------
// Timing: shift completes in this many system clocks
// -------------------------------------------------------------
`define SAS_SHIFT_CYCLES 3'h4

`endif

/* sas_conv_model.sv */
// Converter result path model: one-cycle result pulses at a set spacing.
// Assumes the bench supplies the sample values and gap on the unit's clock.
module sas_conv_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] gap,
    input wire logic [23:0] sample_in,
    output logic conv_valid,
    output logic [23:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt = 0;

    initial
    begin
        conv_valid = 1'b0;
        conv_data = 24'h000000;
    end

    // One pulse per result; off the pulse the data bus shows a changing pattern
    always @(posedge clk)
    begin
        #1;
        conv_valid = 1'b0;
        conv_data = ~sample_in;
        if (run && wait_cnt >= gap)
        begin
            conv_valid = 1'b1;
            conv_data = sample_in;
            wait_cnt = 0;
        end
        else
            wait_cnt = wait_cnt + 1;
    end
endmodule

/* sas_pkg.sv */
// Types shared by the sample accumulate and shift unit.
// Assumes sas_consts.svh is on the include path.
package sas_pkg;
    // Operating modes held in control bits 7..6
    typedef enum logic [1:0] {
        SAS_MODE_MANUAL = 2'h0,
        SAS_MODE_SUM = 2'h1,
        SAS_MODE_SHIFT = 2'h2,
        SAS_MODE_SUM_SHIFT = 2'h3
    } sas_mode_type;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        SAS_ST_IDLE = 3'h1,
        SAS_ST_SUM = 3'h2,
        SAS_ST_SHIFT = 3'h4
    } sas_state_type;
endpackage

/* sas_unit.sv */
// Sample accumulate and shift unit: 32-bit accumulator with right shifter.
// Assumes a single-cycle special-function register port and a converter
// result path on the same clock; all inputs are from same-clock logic.
//
// What this block does
// - Running sum exposed as four byte registers
// - Inactive while converter is powered down
// - Control write of zero clears accumulator
// - Bipolar results sign-extended before adding
// - Control bits 7-6 select four modes
// - Byte 0 write adds held operand
// - Sample count is two to field-plus-one
// - Sum each result, interrupt when count reached
// - Shift field gives shift of 1 to 8
// - Shift-only mode finishes within four clocks
// - Right shift drops bits below LSB
// - Combined mode sums then shifts final sum
// - Sum and combined-mode completion sets summation status flag; shift-only does not
// - Converter result read clears ready flag
`include "sas_consts.svh"

module sas_unit #(
    parameter int CONV_WIDTH = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic conv_powered_up,
    input wire logic conv_bipolar,
    input wire logic conv_valid,
    input wire logic [CONV_WIDTH-1:0] conv_data,
    input wire logic conv_result_rd,
    input wire logic sum_irq_enable,
    input wire logic sum_done_clr,
    output logic sum_done_flag,
    output logic sum_irq,
    output logic converter_ready_flag,
    output logic busy
);

    // ---------------------------------------------------------
    // Register file
    // ---------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [31:0] acc_reg;
    logic [31:0] acc_next;
    logic [31:0] operand_reg;
    logic [7:0] rdata_reg;
    logic sum_done_reg;
    logic conv_ready_reg;
    sas_pkg::sas_state_type state_reg;
    sas_pkg::sas_state_type state_next;
    logic [8:0] sample_cnt_reg;
    logic [2:0] shift_cnt_reg;

    logic wr_ctrl;
    logic wr_sum0;
    sas_pkg::sas_mode_type mode_w;
    sas_pkg::sas_mode_type mode_cur;
    logic [8:0] target_cnt;
    logic [3:0] shift_amt;
    logic [31:0] conv_ext;
    logic sum_last;
    logic finish;

    // Decode of the register port; the byte 0 write needs power present, control writes do not
    assign wr_ctrl = sfr_wr && (sfr_addr == `SAS_ADDR_CTRL);
    assign wr_sum0 = sfr_wr && (sfr_addr == `SAS_ADDR_SUM0) && conv_powered_up;
    assign mode_w = sas_pkg::sas_mode_type'(sfr_wdata[`SAS_MODE_HI:`SAS_MODE_LO]);
    assign mode_cur = sas_pkg::sas_mode_type'(ctrl_reg[`SAS_MODE_HI:`SAS_MODE_LO]);

    // Field decodes: count is a power of two, shift is field plus one
    assign target_cnt = 9'h001 << (ctrl_reg[`SAS_CNT_HI:`SAS_CNT_LO] + 4'h1);
    assign shift_amt = {1'b0, ctrl_reg[`SAS_SHF_HI:`SAS_SHF_LO]} + 4'h1;

    // Widen each result; signed view keeps negative bipolar values right
    assign conv_ext = conv_bipolar ? 32'($signed(conv_data)) : 32'(conv_data);

    assign sum_last = conv_valid && (sample_cnt_reg == target_cnt - 9'h001);
    assign finish = ((state_reg == sas_pkg::SAS_ST_SUM) && sum_last &&
                     (mode_cur == sas_pkg::SAS_MODE_SUM)) ||
                    ((state_reg == sas_pkg::SAS_ST_SHIFT) && (shift_cnt_reg == 3'h1) &&
                     (mode_cur == sas_pkg::SAS_MODE_SUM_SHIFT));

    // ---------------------------------------------------------
    // Control register
    // ---------------------------------------------------------
    // Control is writable even while powered down so that a setup
    // can be staged before the converter is started
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ctrl_reg <= `SAS_CTRL_RESET;
        else if (wr_ctrl)
            ctrl_reg <= sfr_wdata;
    end

    // ---------------------------------------------------------
    // Operand bytes for manual addition
    // ---------------------------------------------------------
    // Bytes 3..1 only stage; byte 0 completes the operand and adds
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            operand_reg <= `SAS_ACC_RESET;
        else if (sfr_wr && conv_powered_up)
        begin
            case (sfr_addr)
                `SAS_ADDR_SUM0: operand_reg[7:0] <= sfr_wdata;
                `SAS_ADDR_SUM1: operand_reg[15:8] <= sfr_wdata;
                `SAS_ADDR_SUM2: operand_reg[23:16] <= sfr_wdata;
                `SAS_ADDR_SUM3: operand_reg[31:24] <= sfr_wdata;
                default: operand_reg <= operand_reg;
            endcase
        end
    end

    // ---------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            sas_pkg::SAS_ST_IDLE:
            begin
                if (wr_ctrl && (mode_w == sas_pkg::SAS_MODE_SHIFT))
                    state_next = sas_pkg::SAS_ST_SHIFT;
                else if (wr_ctrl && mode_w[0])
                    state_next = sas_pkg::SAS_ST_SUM;
            end
            sas_pkg::SAS_ST_SUM:
            begin
                if (sum_last && (mode_cur == sas_pkg::SAS_MODE_SUM_SHIFT))
                    state_next = sas_pkg::SAS_ST_SHIFT;
                else if (sum_last)
                    state_next = sas_pkg::SAS_ST_IDLE;
            end
            sas_pkg::SAS_ST_SHIFT:
            begin
                if (shift_cnt_reg == 3'h1)
                    state_next = sas_pkg::SAS_ST_IDLE;
            end
            default: state_next = sas_pkg::SAS_ST_IDLE;
        endcase
        // A new control write restarts the sequence from its mode
        if (wr_ctrl && (state_reg != sas_pkg::SAS_ST_IDLE))
        begin
            if (mode_w == sas_pkg::SAS_MODE_SHIFT)
                state_next = sas_pkg::SAS_ST_SHIFT;
            else if (mode_w[0])
                state_next = sas_pkg::SAS_ST_SUM;
            else
                state_next = sas_pkg::SAS_ST_IDLE;
        end
        if (!conv_powered_up)
            state_next = sas_pkg::SAS_ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_reg <= sas_pkg::SAS_ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Sample counter, restarted on every control write
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sample_cnt_reg <= 9'h000;
        else if (wr_ctrl)
            sample_cnt_reg <= 9'h000;
        else if ((state_reg == sas_pkg::SAS_ST_SUM) && conv_valid && conv_powered_up)
            sample_cnt_reg <= sample_cnt_reg + 9'h001;
    end

    // Shift timer: loaded on entry, shift lands on its last count.
    // A shift-mode rewrite in mid-shift reloads it, so the new amount
    // still gets the full four clocks
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            shift_cnt_reg <= 3'h0;
        else if ((state_next == sas_pkg::SAS_ST_SHIFT) &&
                 ((state_reg != sas_pkg::SAS_ST_SHIFT) || wr_ctrl))
            shift_cnt_reg <= `SAS_SHIFT_CYCLES;
        else if ((state_reg == sas_pkg::SAS_ST_SHIFT) && (shift_cnt_reg != 3'h0))
            shift_cnt_reg <= shift_cnt_reg - 3'h1;
    end

    // ---------------------------------------------------------
    // Accumulator datapath
    // ---------------------------------------------------------
    always_comb
    begin
        acc_next = acc_reg;
        if (!conv_powered_up)
            acc_next = acc_reg;
        else if (wr_ctrl && (sfr_wdata == 8'h00))
            acc_next = `SAS_ACC_RESET;
        else if (wr_sum0 && (mode_cur == sas_pkg::SAS_MODE_MANUAL))
            acc_next = acc_reg + {operand_reg[31:8], sfr_wdata};
        else if ((state_reg == sas_pkg::SAS_ST_SUM) && conv_valid)
            acc_next = acc_reg + conv_ext;
        else if ((state_reg == sas_pkg::SAS_ST_SHIFT) && (shift_cnt_reg == 3'h1))
            acc_next = acc_reg >> shift_amt;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            acc_reg <= `SAS_ACC_RESET;
        else
            acc_reg <= acc_next;
    end

    // ---------------------------------------------------------
    // Status flags
    // ---------------------------------------------------------
    // Completion wins over a clear arriving in the same cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sum_done_reg <= 1'b0;
        else if (finish)
            sum_done_reg <= 1'b1;
        else if (sum_done_clr)
            sum_done_reg <= 1'b0;
    end

    // A new result outranks the read that would clear the old one
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            conv_ready_reg <= 1'b0;
        else if (conv_valid && conv_powered_up)
            conv_ready_reg <= 1'b1;
        else if (conv_result_rd)
            conv_ready_reg <= 1'b0;
    end

    // ---------------------------------------------------------
    // Read data, one clock after the read strobe
    // ---------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_reg <= `SAS_UNMAPPED_READ;
        else if (sfr_rd)
        begin
            case (sfr_addr)
                `SAS_ADDR_CTRL: rdata_reg <= ctrl_reg;
                `SAS_ADDR_SUM0: rdata_reg <= acc_reg[7:0];
                `SAS_ADDR_SUM1: rdata_reg <= acc_reg[15:8];
                `SAS_ADDR_SUM2: rdata_reg <= acc_reg[23:16];
                `SAS_ADDR_SUM3: rdata_reg <= acc_reg[31:24];
                default: rdata_reg <= `SAS_UNMAPPED_READ;
            endcase
        end
    end

    assign sfr_rdata = rdata_reg;
    assign sum_done_flag = sum_done_reg;
    assign sum_irq = sum_done_reg && sum_irq_enable;
    assign converter_ready_flag = conv_ready_reg;
    assign busy = (state_reg != sas_pkg::SAS_ST_IDLE);

    // ---------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    clear_on_zero_a: assert property (
        (wr_ctrl && sfr_wdata == 8'h00 && conv_powered_up) |=> acc_reg == 32'h0)
        else $error("zero control write did not clear sum");
    manual_add_a: assert property (
        (wr_sum0 && mode_cur == sas_pkg::SAS_MODE_MANUAL && !wr_ctrl)
        |=> acc_reg == $past(acc_reg) + $past({operand_reg[31:8], sfr_wdata}))
        else $error("manual add result wrong");
    sign_extend_a: assert property (
        (state_reg == sas_pkg::SAS_ST_SUM && conv_valid && conv_powered_up && !wr_ctrl
         && conv_bipolar && conv_data[CONV_WIDTH-1])
        |=> acc_reg == $past(acc_reg) + $past(32'($signed(conv_data))))
        else $error("bipolar sample not sign extended");
    shift_four_a: assert property (
        (wr_ctrl && mode_w == sas_pkg::SAS_MODE_SHIFT && conv_powered_up)
        ##1 (!wr_ctrl && conv_powered_up) [*4]
        |=> state_reg == sas_pkg::SAS_ST_IDLE
            && acc_reg == ($past(acc_reg) >> $past(shift_amt)))
        else $error("shift did not finish in four clocks");
    shift_value_a: assert property (
        (state_reg == sas_pkg::SAS_ST_SHIFT && shift_cnt_reg == 3'h1 && !wr_ctrl
         && conv_powered_up) |=> acc_reg == ($past(acc_reg) >> $past(shift_amt)))
        else $error("shift amount wrong");
    powered_down_a: assert property (
        !conv_powered_up |=> acc_reg == $past(acc_reg) && !busy)
        else $error("sum changed while powered down");
    done_irq_a: assert property (
        finish |=> sum_done_flag ##0 (sum_irq == sum_irq_enable))
        else $error("summation done flag not raised");
    combined_shift_a: assert property (
        (state_reg == sas_pkg::SAS_ST_SUM && sum_last && !wr_ctrl && conv_powered_up
         && mode_cur == sas_pkg::SAS_MODE_SUM_SHIFT) |=> state_reg == sas_pkg::SAS_ST_SHIFT)
        else $error("combined mode skipped shift");
    ready_clear_a: assert property (
        (conv_result_rd && !(conv_valid && conv_powered_up)) |=> !converter_ready_flag)
        else $error("result read did not clear ready flag");
    byte_read_a: assert property (
        (sfr_rd && sfr_addr == `SAS_ADDR_SUM3) |=> sfr_rdata == $past(acc_reg[31:24]))
        else $error("top byte read wrong");

    manual_add_c: cover property (wr_sum0 && mode_cur == sas_pkg::SAS_MODE_MANUAL);
    sum_done_c: cover property (finish && mode_cur == sas_pkg::SAS_MODE_SUM);
    avg_done_c: cover property (finish && mode_cur == sas_pkg::SAS_MODE_SUM_SHIFT);
    shift_only_c: cover property (state_reg == sas_pkg::SAS_ST_SHIFT
        && mode_cur == sas_pkg::SAS_MODE_SHIFT && shift_cnt_reg == 3'h1);

endmodule

/* tb_sample_accumulate_shift_unit.sv */
// Self-checking bench for the sample accumulate and shift unit.
// Assumes sas_consts.svh on the include path and the converter model.
`include "sas_consts.svh"
module tb_sample_accumulate_shift_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic conv_powered_up = 1'b1;
    logic conv_bipolar = 1'b0;
    logic conv_valid;
    logic [23:0] conv_data;
    logic conv_result_rd = 1'b0;
    logic sum_irq_enable = 1'b0;
    logic sum_done_clr = 1'b0;
    logic sum_done_flag, sum_irq, converter_ready_flag, busy;
    logic run = 1'b0;
    logic [3:0] gap = 4'h0;
    logic [31:0] lfsr_state = 32'h0000_0036;
    logic [31:0] m_acc = 32'h0000_0000;
    int cnt_left = 0;
    int miscompares = 0;
    int num_checks = 0;

    sas_unit u_sas_unit (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .conv_powered_up(conv_powered_up), .conv_bipolar(conv_bipolar),
        .conv_valid(conv_valid), .conv_data(conv_data), .conv_result_rd(conv_result_rd),
        .sum_irq_enable(sum_irq_enable), .sum_done_clr(sum_done_clr),
        .sum_done_flag(sum_done_flag), .sum_irq(sum_irq),
        .converter_ready_flag(converter_ready_flag), .busy(busy));
    sas_conv_model u_sas_conv_model (.clk(clk), .run(run), .gap(gap),
        .sample_in(lfsr_state[23:0]), .conv_valid(conv_valid), .conv_data(conv_data));

    initial
    begin
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Random source steps every rising edge so samples and operands keep changing
    always @(posedge clk) lfsr_state <= lfsr_next(lfsr_state);

    // Reference sum: only results taken while a count is still pending
    always @(posedge clk)
    begin
        if (conv_valid === 1'b1 && cnt_left > 0)
        begin
            m_acc = m_acc + (conv_bipolar ? {{8{conv_data[23]}}, conv_data} : {8'h00, conv_data});
            cnt_left = cnt_left - 1;
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(posedge clk);
        #1 sfr_wr = 1'b0;
    endtask

    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 sfr_rd = 1'b1;
        sfr_addr = a;
        @(posedge clk);
        #1 sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask

    // Byte 0 holds the low end of the sum
    task automatic check_acc();
        logic [31:0] v;
        for (int i = 0; i < 4; i++) rd8(8'(`SAS_ADDR_SUM0 + i), v[8*i +: 8]);
        chk_val(v, m_acc);
    endtask

    // Upper bytes first: the byte 0 write launches the addition
    task automatic add(input logic [31:0] val);
        for (int i = 3; i >= 0; i--) wr(8'(`SAS_ADDR_SUM0 + i), val[8*i +: 8]);
        m_acc = m_acc + val;
    endtask

    task automatic load(input logic [31:0] val);
        wr(`SAS_ADDR_CTRL, 8'h00);
        m_acc = 32'h0000_0000;
        add(val);
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        while (busy !== 1'b0 && n < 2000)
        begin
            @(posedge clk);
            #1 n++;
        end
        // A sequence that never ends counts as a mismatch
        if (n >= 2000)
            miscompares++;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog: the whole run needs under some three thousand clocks, so
    // fifty thousand leaves a wide margin
    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        int n;
        logic [7:0] c;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        check_acc();
        rd8(`SAS_ADDR_CTRL, c);
        chk_val({24'h000000, c}, 32'(`SAS_CTRL_RESET));
        rd8(8'hF0, c);
        chk_val({24'h000000, c}, 32'(`SAS_UNMAPPED_READ));
        load(32'h0012_3456);
        add(32'h0051_AB04);
        check_acc();
        repeat (3)
        begin
            add(lfsr_state);
            check_acc();
        end
        wr(`SAS_ADDR_CTRL, 8'h00);
        m_acc = 32'h0000_0000;
        check_acc();
        // Every shift amount on an operand with both end bits set
        for (int s = 0; s < 8; s++)
        begin
            load(lfsr_state | 32'h8000_0001);
            wr(`SAS_ADDR_CTRL, 8'(8'h80 | s));
            m_acc = m_acc >> (s + 1);
            wait_idle(n);
            chk_flag(n <= 4, 1'b1);
            chk_flag(sum_done_flag, 1'b0);
            check_acc();
        end
        // Every count code, even codes summation alone and odd codes with shift, both formats
        for (int k = 0; k < 8; k++)
        begin
            wr(`SAS_ADDR_CTRL, 8'h00);
            m_acc = 32'h0000_0000;
            conv_bipolar = k[1];
            sum_irq_enable = k[2];
            gap = lfsr_state[3:0] & 4'h3;
            c = {k[0], 1'b1, 3'(k), 3'(7 - k)};
            wr(`SAS_ADDR_CTRL, c);
            cnt_left = 2 << k;
            run = 1'b1;
            n = 0;
            while (cnt_left > 0 && n < 3000)
            begin
                @(posedge clk);
                #1 n++;
            end
            if (n >= 3000)
                miscompares++;
            wait_idle(n);
            run = 1'b0;
            if (k[0])
                m_acc = m_acc >> (8 - k);
            chk_flag(sum_done_flag, 1'b1);
            chk_flag(sum_irq, k[2]);
            check_acc();
            @(posedge clk);
            #1 sum_done_clr = 1'b1;
            @(posedge clk);
            #1 sum_done_clr = 1'b0;
            chk_flag(sum_done_flag, 1'b0);
        end
        chk_flag(converter_ready_flag, 1'b1);
        @(posedge clk);
        #1 conv_result_rd = 1'b1;
        @(posedge clk);
        #1 conv_result_rd = 1'b0;
        chk_flag(converter_ready_flag, 1'b0);
        // Powered down: sum writes and results have no effect
        load(lfsr_state);
        conv_powered_up = 1'b0;
        wr(`SAS_ADDR_SUM0, 8'h11);
        wr(`SAS_ADDR_CTRL, 8'h40);
        run = 1'b1;
        repeat (10) @(posedge clk);
        #1 run = 1'b0;
        chk_flag(busy, 1'b0);
        chk_flag(converter_ready_flag, 1'b0);
        check_acc();
        wrap_up();
    end
endmodule
